// file: shared/dac_cfg_pkg.sv
// Purpose: Shared constants and carriers for the dual channel configuration bank.
// Assumes: 24-bit serial frames, MSB first: read flag, 7-bit address, 16-bit data.
// Notes:   Every offset, field position and reset value is named here once.
package dac_cfg_pkg;

  // Sizes of the bank and the frame.
  localparam int NUM_CHAN    = 2;
  localparam int DATA_W      = 16;
  localparam int ADDR_W      = 7;
  localparam int FRAME_BITS  = 24;
  localparam int FRAME_CNT_W = 5;
  localparam int SPAN_W      = 4;
  localparam int VOLT_W      = 6;

  // Register offsets.
  localparam logic [ADDR_W-1:0] ADDR_BCAST_SEL   = 7'h05;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_SEL    = 7'h06;
  localparam logic [ADDR_W-1:0] ADDR_PWDN        = 7'h09;
  localparam logic [ADDR_W-1:0] ADDR_SPAN        = 7'h0a;
  localparam logic [ADDR_W-1:0] ADDR_TRIGGER     = 7'h0e;
  localparam logic [ADDR_W-1:0] ADDR_GROUP_WRITE = 7'h0f;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_A_DATA = 7'h11;
  localparam logic [ADDR_W-1:0] ADDR_CHAN_B_DATA = 7'h12;

  // Field positions: channel A at the low bit, channel B one above.
  localparam int CHAN_BIT_LSB     = 1;
  localparam int SPAN_LSB         = 4;
  localparam int TRIG_SW_LOAD_BIT = 4;
  localparam logic [DATA_W-1:0] CHAN_FIELD_MASK = 16'h0006;

  // Reset values of the four configuration registers.
  localparam logic [DATA_W-1:0] RST_BCAST_SEL = 16'h000f;
  localparam logic [DATA_W-1:0] RST_SYNC_SEL  = 16'h0000;
  localparam logic [DATA_W-1:0] RST_PWDN      = 16'h0fff;
  localparam logic [DATA_W-1:0] RST_SPAN      = 16'h0000;

  // Output span codes.
  localparam logic [SPAN_W-1:0] SPAN_U5  = 4'h0;
  localparam logic [SPAN_W-1:0] SPAN_U10 = 4'h1;
  localparam logic [SPAN_W-1:0] SPAN_U20 = 4'h2;
  localparam logic [SPAN_W-1:0] SPAN_B5  = 4'h3;
  localparam logic [SPAN_W-1:0] SPAN_U40 = 4'h4;
  localparam logic [SPAN_W-1:0] SPAN_B10 = 4'h6;
  localparam logic [SPAN_W-1:0] SPAN_B20 = 4'h7;
  localparam logic [SPAN_W-1:0] SPAN_U6  = 4'h8;
  localparam logic [SPAN_W-1:0] SPAN_U12 = 4'h9;
  localparam logic [SPAN_W-1:0] SPAN_B6  = 4'hd;
  localparam logic [SPAN_W-1:0] SPAN_B12 = 4'he;

  // One received serial frame.
  typedef struct packed {
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } frame_s;

  // Decoded span of one channel; volts is the full scale magnitude.
  typedef struct packed {
    logic              valid;
    logic              bipolar;
    logic [VOLT_W-1:0] volts;
  } span_info_s;

endpackage : dac_cfg_pkg

// file: hdl/spi_frame_rx.sv
// Purpose: Oversampled serial slave that turns one framed transfer into a frame pulse.
// Assumes: Serial clock well below a quarter of i_clk; pins are asynchronous.
// Notes:   Frames whose bit count is not exactly the frame length are dropped.
`timescale 1ns/1ns
module spi_frame_rx
  (
    // Clock and reset.
    input  wire logic                        i_clk,
    input  wire logic                        i_resetn,
    // Serial pins.
    input  wire logic                        i_sclk,
    input  wire logic                        i_sdi,
    input  wire logic                        i_frame_sel_n,
    // Readback word shifted out in the next frame.
    input  wire logic [dac_cfg_pkg::DATA_W-1:0] i_rd_data,
    // Received frame.
    output logic                             o_frame_valid,
    output dac_cfg_pkg::frame_s              o_frame,
    // Serial data out and its enable.
    output logic                             o_sdo,
    output logic                             o_sdo_oe
  );
  import dac_cfg_pkg::*;

  typedef enum logic {RX_IDLE, RX_SHIFT} rx_state_e;

  logic [2:0]             meta_q;    // First stage: {sel_n, sclk, sdi}.
  logic [2:0]             sync_q;    // Second stage, safe to use.
  logic [2:0]             prev_q;    // Delayed copy for edge detection.
  rx_state_e              state_q, state_d;
  logic [FRAME_CNT_W-1:0] cnt_q, cnt_d;
  logic [FRAME_BITS-1:0]  shin_q, shin_d;
  logic [FRAME_BITS-1:0]  shout_q, shout_d;
  logic                   sdo_q, sdo_d;
  logic                   oe_q, oe_d;
  logic                   valid_q, valid_d;
  frame_s                 frame_q, frame_d;
  logic                   sel_fall, sel_rise, sclk_rise, sclk_fall;

  // Edges come only from the second and third stages, never the first.
  assign sel_fall  = prev_q[2] & ~sync_q[2];
  assign sel_rise  = ~prev_q[2] & sync_q[2];
  assign sclk_rise = ~prev_q[1] & sync_q[1];
  assign sclk_fall = prev_q[1] & ~sync_q[1];

  // Pin synchroniser; select idles high so it resets high.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      meta_q <= 3'h4;
      sync_q <= 3'h4;
      prev_q <= 3'h4;
    end
    else
    begin
      meta_q <= {i_frame_sel_n, i_sclk, i_sdi};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  // Frame sequencing: shift in on rising clock, shift out on falling clock.
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    shin_d  = shin_q;
    shout_d = shout_q;
    sdo_d   = sdo_q;
    oe_d    = oe_q;
    frame_d = frame_q;
    valid_d = 1'b0;
    case (state_q)
      RX_IDLE:
      begin
        if (sel_fall)
        begin
          // The readback word is latched here, so a read lands one frame late.
          state_d = RX_SHIFT;
          cnt_d   = '0;
          shout_d = {{(FRAME_BITS-DATA_W){1'b0}}, i_rd_data};
          sdo_d   = 1'b0;
          oe_d    = 1'b1;
        end
      end
      RX_SHIFT:
      begin
        if (sel_rise)
        begin
          state_d = RX_IDLE;
          oe_d    = 1'b0;
          sdo_d   = 1'b0;
          // A short or long frame is ignored to keep stray clocks harmless.
          if (cnt_q == FRAME_CNT_W'(FRAME_BITS))
          begin
            frame_d = frame_s'(shin_q);
            valid_d = 1'b1;
          end
        end
        else
        begin
          if (sclk_rise)
          begin
            shin_d = {shin_q[FRAME_BITS-2:0], sync_q[0]};
            if (cnt_q != {FRAME_CNT_W{1'b1}})
            begin
              cnt_d = cnt_q + FRAME_CNT_W'(1);
            end
          end
          if (sclk_fall)
          begin
            shout_d = {shout_q[FRAME_BITS-2:0], 1'b0};
            sdo_d   = shout_q[FRAME_BITS-2];
          end
        end
      end
      default:
      begin
        state_d = RX_IDLE;
      end
    endcase
  end

  // Frame state registers.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_q <= RX_IDLE;
      cnt_q   <= '0;
      shin_q  <= '0;
      shout_q <= '0;
      sdo_q   <= 1'b0;
      oe_q    <= 1'b0;
      valid_q <= 1'b0;
      frame_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shin_q  <= shin_d;
      shout_q <= shout_d;
      sdo_q   <= sdo_d;
      oe_q    <= oe_d;
      valid_q <= valid_d;
      frame_q <= frame_d;
    end
  end

  assign o_frame_valid = valid_q;
  assign o_frame       = frame_q;
  assign o_sdo         = sdo_q;
  assign o_sdo_oe      = oe_q;

endmodule : spi_frame_rx

// file: hdl/dual_dac_channel_config_regs.sv
// Purpose: Per-channel broadcast, update mode, sleep and span registers of a dual converter.
// Assumes: Host writes only defined span codes; pins arrive asynchronously.
// Notes:   Immediate channel data is applied when the received frame is committed after select rises.
`timescale 1ns/1ns
// Notes on behaviour
// - Joined channel takes group write value.
// - Unjoined channel ignores group writes.
// - Deferred channel holds data until load.
// - Immediate channel updates when frame ends.
// - Sleep bit grounds the channel output.
// - Both channels asleep after reset.
// - Both channels join group after reset.
// - Both channels immediate after reset.
// - Span codes in bits 11:8, 7:4.
// - Span register clears at reset.
// - Codes 0000, 0001 give 5, 10 V.
// - Codes 1000, 1001 give 6, 12 V.
// - Codes 0011, 0110, 0111 bipolar 5/10/20.
// - Codes 1101, 1110 bipolar 6, 12.
// - Software load applies deferred channels' data.
// - Group write loads every joined channel.
module dual_dac_channel_config_regs
  (
    // Clock and reset.
    input  wire logic                         i_clk,
    input  wire logic                         i_resetn,
    // Serial interface pins.
    input  wire logic                         i_sclk,
    input  wire logic                         i_sdi,
    input  wire logic                         i_frame_sel_n,
    output logic                              o_sdo,
    output logic                              o_sdo_oe,
    // Load trigger pin, active low.
    input  wire logic                         i_load_trigger_n,
    // Channel outputs.
    output logic [dac_cfg_pkg::NUM_CHAN-1:0][dac_cfg_pkg::DATA_W-1:0] o_chan_code,
    output logic [dac_cfg_pkg::NUM_CHAN-1:0]  o_chan_sleep,
    output dac_cfg_pkg::span_info_s [dac_cfg_pkg::NUM_CHAN-1:0] o_span_info
  );
  import dac_cfg_pkg::*;

  localparam int SPAN_ALL = NUM_CHAN * SPAN_W;

  logic                                frame_valid;    // One-cycle frame commit.
  frame_s                              frame;          // Committed frame.
  logic                                ld_meta_q;      // Load pin, first stage.
  logic                                ld_sync_q;      // Load pin, second stage.
  logic                                ld_prev_q;      // Load pin, for edge detect.
  logic [NUM_CHAN-1:0]                 bcast_q, bcast_d;
  logic [NUM_CHAN-1:0]                 defer_q, defer_d;
  logic [NUM_CHAN-1:0]                 sleep_q, sleep_d;
  logic [NUM_CHAN-1:0][SPAN_W-1:0]     span_q, span_d;
  logic [NUM_CHAN-1:0][DATA_W-1:0]     held_q, held_d;  // Data waiting for a load.
  logic [NUM_CHAN-1:0][DATA_W-1:0]     code_q, code_d;  // Data driving the output.
  span_info_s [NUM_CHAN-1:0]           info_q, info_d;
  logic [DATA_W-1:0]                   rd_q, rd_d;
  logic [NUM_CHAN-1:0]                 touched;        // Channel written this frame.
  logic                                wr;
  logic                                sw_load;
  logic                                hw_load;

  // Serial framing lives in its own module; it also shifts the readback out.
  spi_frame_rx u_spi_frame_rx
  (
    .i_clk         (i_clk),
    .i_resetn      (i_resetn),
    .i_sclk        (i_sclk),
    .i_sdi         (i_sdi),
    .i_frame_sel_n (i_frame_sel_n),
    .i_rd_data     (rd_q),
    .o_frame_valid (frame_valid),
    .o_frame       (frame),
    .o_sdo         (o_sdo),
    .o_sdo_oe      (o_sdo_oe)
  );

  // Span decode; undefined codes flag invalid and their scale is meaningless.
  function automatic span_info_s span_decode(input logic [SPAN_W-1:0] code);
    span_info_s s;
    s = '{valid: 1'b1, bipolar: 1'b0, volts: '0};
    case (code)
      SPAN_U5:  s.volts = 6'h05;
      SPAN_U10: s.volts = 6'h0a;
      SPAN_U6:  s.volts = 6'h06;
      SPAN_U12: s.volts = 6'h0c;
      SPAN_U20: s.volts = 6'h14;
      SPAN_U40: s.volts = 6'h28;
      SPAN_B5:  s = '{valid: 1'b1, bipolar: 1'b1, volts: 6'h05};
      SPAN_B10: s = '{valid: 1'b1, bipolar: 1'b1, volts: 6'h0a};
      SPAN_B20: s = '{valid: 1'b1, bipolar: 1'b1, volts: 6'h14};
      SPAN_B6:  s = '{valid: 1'b1, bipolar: 1'b1, volts: 6'h06};
      SPAN_B12: s = '{valid: 1'b1, bipolar: 1'b1, volts: 6'h0c};
      default:  s.valid = 1'b0;
    endcase
    return s;
  endfunction : span_decode

  // Readback word; reserved bits come from the reset constant, span is write-only.
  function automatic logic [DATA_W-1:0] read_word(input logic [ADDR_W-1:0] addr,
                                                  input logic [NUM_CHAN-1:0] bc,
                                                  input logic [NUM_CHAN-1:0] df,
                                                  input logic [NUM_CHAN-1:0] sl);
    logic [DATA_W-1:0] w;
    w = '0;
    case (addr)
      ADDR_BCAST_SEL: w = (RST_BCAST_SEL & ~CHAN_FIELD_MASK) | (DATA_W'(bc) << CHAN_BIT_LSB);
      ADDR_SYNC_SEL:  w = (RST_SYNC_SEL & ~CHAN_FIELD_MASK) | (DATA_W'(df) << CHAN_BIT_LSB);
      ADDR_PWDN:      w = (RST_PWDN & ~CHAN_FIELD_MASK) | (DATA_W'(sl) << CHAN_BIT_LSB);
      default:        w = '0;
    endcase
    return w;
  endfunction : read_word

  assign wr      = frame_valid & ~frame.rd;
  assign hw_load = ld_prev_q & ~ld_sync_q;

  // Load pin synchroniser; the falling edge is the trigger.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ld_meta_q <= 1'b1;
      ld_sync_q <= 1'b1;
      ld_prev_q <= 1'b1;
    end
    else
    begin
      ld_meta_q <= i_load_trigger_n;
      ld_sync_q <= ld_meta_q;
      ld_prev_q <= ld_sync_q;
    end
  end

  // Register writes, readback capture and per-channel update selection.
  always_comb
  begin
    bcast_d = bcast_q;
    defer_d = defer_q;
    sleep_d = sleep_q;
    span_d  = span_q;
    held_d  = held_q;
    code_d  = code_q;
    info_d  = info_q;
    rd_d    = rd_q;
    touched = '0;
    sw_load = 1'b0;
    if (frame_valid && frame.rd)
    begin
      rd_d = read_word(frame.addr, bcast_q, defer_q, sleep_q);
    end
    if (wr)
    begin
      // Select registers keep only the channel bits, span only bits 11:4; reserved bits are dropped.
      case (frame.addr)
        ADDR_BCAST_SEL:   bcast_d = frame.data[CHAN_BIT_LSB +: NUM_CHAN];
        ADDR_SYNC_SEL:    defer_d = frame.data[CHAN_BIT_LSB +: NUM_CHAN];
        ADDR_PWDN:        sleep_d = frame.data[CHAN_BIT_LSB +: NUM_CHAN];
        ADDR_SPAN:        span_d  = frame.data[SPAN_LSB +: SPAN_ALL];
        ADDR_TRIGGER:     sw_load = frame.data[TRIG_SW_LOAD_BIT];
        ADDR_GROUP_WRITE: touched = bcast_q;
        ADDR_CHAN_A_DATA: touched = 2'h1;
        ADDR_CHAN_B_DATA: touched = 2'h2;
        default:          touched = '0;
      endcase
    end
    for (int ch = 0; ch < NUM_CHAN; ch++)
    begin
      if (touched[ch])
      begin
        held_d[ch] = frame.data;
      end
      if (touched[ch] && !defer_q[ch])
      begin
        // Immediate mode: the frame end itself applies the data.
        code_d[ch] = frame.data;
      end
      else if ((hw_load || sw_load) && defer_q[ch])
      begin
        // Deferred mode: only a trigger moves held data to the output.
        code_d[ch] = held_q[ch];
      end
      info_d[ch] = span_decode(span_q[ch]);
    end
  end

  // Configuration and channel state registers.
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      bcast_q <= RST_BCAST_SEL[CHAN_BIT_LSB +: NUM_CHAN];
      defer_q <= RST_SYNC_SEL[CHAN_BIT_LSB +: NUM_CHAN];
      sleep_q <= RST_PWDN[CHAN_BIT_LSB +: NUM_CHAN];
      span_q  <= RST_SPAN[SPAN_LSB +: SPAN_ALL];
      held_q  <= '0;
      code_q  <= '0;
      info_q  <= '0;
      rd_q    <= '0;
    end
    else
    begin
      bcast_q <= bcast_d;
      defer_q <= defer_d;
      sleep_q <= sleep_d;
      span_q  <= span_d;
      held_q  <= held_d;
      code_q  <= code_d;
      info_q  <= info_d;
      rd_q    <= rd_d;
    end
  end

  // The sleep output drives the grounding switch; the code is kept for wake-up.
  assign o_chan_code  = code_q;
  assign o_chan_sleep = sleep_q;
  assign o_span_info  = info_q;

  group_join_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr && frame.addr == ADDR_GROUP_WRITE && bcast_q[0] && !defer_q[0]
    |=> code_q[0] == $past(frame.data))
    else $error("joined channel missed group write");

  group_skip_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr && frame.addr == ADDR_GROUP_WRITE && !bcast_q[0] && !defer_q[0]
    |=> $stable(code_q[0]) && $stable(held_q[0]))
    else $error("unjoined channel changed on group write");

  defer_hold_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr && frame.addr == ADDR_CHAN_A_DATA && defer_q[0] && !hw_load
    |=> $stable(code_q[0]) ##1 held_q[0] == $past(frame.data, 2))
    else $error("deferred channel updated without load");

  sw_load_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr && frame.addr == ADDR_TRIGGER && frame.data[TRIG_SW_LOAD_BIT] && defer_q[1]
    |=> code_q[1] == $past(held_q[1]))
    else $error("software load did not apply held data");

  immediate_update_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr && frame.addr == ADDR_CHAN_B_DATA && !defer_q[1]
    |=> code_q[1] == $past(frame.data))
    else $error("immediate channel did not update at frame end");

  sleep_write_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr && frame.addr == ADDR_PWDN |=> o_chan_sleep == $past(frame.data[2:1]))
    else $error("sleep output does not follow its register");

  reset_state_a : assert property (@(posedge i_clk)
    $rose(i_resetn) |-> o_chan_sleep == 2'h3 && bcast_q == 2'h3
                        && defer_q == 2'h0 && span_q == '0)
    else $error("wrong state after reset");

  span_field_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    wr && frame.addr == ADDR_SPAN
    |=> span_q[1] == $past(frame.data[11:8]) && span_q[0] == $past(frame.data[7:4]))
    else $error("span fields taken from wrong bits");

  span_unipolar_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    span_q[0] == 4'h9
    |=> o_span_info[0] == span_info_s'{valid: 1'b1, bipolar: 1'b0, volts: 6'h0c})
    else $error("code 1001 not decoded as 0 to 12 V");

  span_bipolar_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    span_q[1] == 4'h7 |=> o_span_info[1].bipolar && o_span_info[1].volts == 6'h14)
    else $error("code 0111 not decoded as 20 V bipolar");

  reserved_read_a : assert property (@(posedge i_clk) disable iff (!i_resetn)
    frame_valid && frame.rd && frame.addr == ADDR_PWDN
    |=> rd_q[15:12] == 4'h0 && rd_q[11:3] == 9'h1ff && rd_q[0])
    else $error("reserved readback bits wrong");

endmodule : dual_dac_channel_config_regs

// file: tb/spi_host_model.sv
// Purpose: Behavioural serial host that sends framed transfers to the configuration bank.
// Assumes: Pins change only on falling edges of i_clk, several clock cycles per serial phase.
// Notes:   The serial clock stands low outside frames and data in flips when released.
`timescale 1ns/1ns
module spi_host_model
  (
    // Clock that paces the pins.
    input  wire logic i_clk,
    // Serial pins toward the device.
    output logic      o_sclk,
    output logic      o_sdi,
    output logic      o_frame_sel_n,
    // Serial data back from the device.
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe
  );
  // Cycles per serial phase; the device needs at least four.
  localparam int HALF = 5;

  // Idle pins before the first frame.
  initial
  begin
    o_sclk        = 1'b0;
    o_sdi         = 1'b0;
    o_frame_sel_n = 1'b1;
  end

  // Waits a number of falling clock edges.
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_clk);
  endtask : wait_clk

  // Sends one frame of nbits bits, MSB first, and gathers what the device shifts out.
  // A short count is allowed so that a scenario can send a frame that must be dropped.
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [15:0] data,
                      input int nbits, output logic [23:0] rx);
    logic [23:0] word;
    word = {rd, addr, data};
    rx   = '0;
    @(negedge i_clk);
    o_frame_sel_n = 1'b0;
    wait_clk(HALF);
    for (int i = 0; i < nbits; i++)
    begin
      o_sdi = word[23-i];
      wait_clk(HALF);
      o_sclk = 1'b1;
      // An undriven output reads as unknown so that it can never match.
      rx[23-i] = i_sdo_oe ? i_sdo : 1'bx;
      wait_clk(HALF);
      o_sclk = 1'b0;
    end
    wait_clk(HALF);
    o_frame_sel_n = 1'b1;
    // Released data line shows the inverse so no stale bit looks valid.
    o_sdi = ~o_sdi;
    // Gap covers the device's commit latency and the minimum idle time.
    wait_clk(10);
  endtask : xfer

endmodule : spi_host_model

// file: tb/test_dual_dac_channel_config_regs.sv
// Purpose: Self-checking bench for the dual channel configuration bank.
// Assumes: Host model sends 24-bit frames; readback arrives in the following frame.
// Notes:   Expected values come from the register map, never from the outputs.
`timescale 1ns/1ns
module test_dual_dac_channel_config_regs;
  import dac_cfg_pkg::*;
  logic                                 i_clk;
  logic                                 i_resetn;
  logic                                 sclk, sdi, sel_n, sdo, sdo_oe;
  logic                                 load_n;
  logic [NUM_CHAN-1:0][DATA_W-1:0]      chan_code;
  logic [NUM_CHAN-1:0]                  chan_sleep;
  span_info_s [NUM_CHAN-1:0]            span_info;
  int                                   n_errors  = 0;
  int                                   cmp_count = 0;
  int                                   cyc       = 0;
  logic [23:0]                          rx;
  logic [15:0]                          v;
  // Span table: only defined codes are ever written.
  logic [3:0] codes [11] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hd, 4'he};
  logic [0:10] bip = 11'b00010110011;
  logic [5:0] volts [11] = '{6'h05, 6'h0a, 6'h14, 6'h05, 6'h28, 6'h0a, 6'h14, 6'h06, 6'h0c,
                             6'h06, 6'h0c};

  dual_dac_channel_config_regs u_dual_dac_channel_config_regs (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_sclk(sclk), .i_sdi(sdi), .i_frame_sel_n(sel_n),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_load_trigger_n(load_n), .o_chan_code(chan_code),
    .o_chan_sleep(chan_sleep), .o_span_info(span_info));

  spi_host_model u_spi_host_model (
    .i_clk(i_clk), .o_sclk(sclk), .o_sdi(sdi), .o_frame_sel_n(sel_n),
    .i_sdo(sdo), .i_sdo_oe(sdo_oe));

  // Free-running 50 MHz clock.
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Prints counts and the verdict, then stops.
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : finish_test

  // Cuts a hang short; the full run needs roughly 12000 cycles.
  always @(posedge i_clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      $display("BAD t=%0t run did not finish in time", $time);
      finish_test();
    end
  end

  // Compares one value and counts the result.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("BAD t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  // Register write in one frame.
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    u_spi_host_model.xfer(1'b0, a, d, 24, rx);
  endtask : wr

  // Register read: the answer is shifted out during a second, harmless frame.
  task automatic rchk(input logic [6:0] a, input logic [15:0] exp);
    u_spi_host_model.xfer(1'b1, a, 16'h0000, 24, rx);
    u_spi_host_model.xfer(1'b1, 7'h00, 16'h0000, 24, rx);
    chk(rx, {8'h00, exp}, "readback");
  endtask : rchk

  // Main sequence.
  initial
  begin
    i_resetn = 1'b0;
    load_n   = 1'b1;
    repeat (3) @(negedge i_clk);
    i_resetn = 1'b1;
    repeat (4) @(negedge i_clk);
    chk(chan_sleep, 2'b11, "sleep at reset");
    chk(chan_code, 32'h0, "codes at reset");
    chk(span_info, 16'h8585, "span at reset");
    rchk(ADDR_BCAST_SEL, 16'h000f);
    rchk(ADDR_SYNC_SEL, 16'h0000);
    rchk(ADDR_PWDN, 16'h0fff);
    rchk(ADDR_SPAN, 16'h0000);
    $display("test reset values done");
    wr(ADDR_CHAN_A_DATA, 16'h1234);
    chk(chan_code[0], 16'h1234, "immediate A");
    wr(ADDR_CHAN_B_DATA, 16'habcd);
    chk(chan_code[1], 16'habcd, "immediate B");
    $display("test immediate update done");
    wr(ADDR_SYNC_SEL, 16'hffff);
    rchk(ADDR_SYNC_SEL, 16'h0006);
    wr(ADDR_CHAN_A_DATA, 16'h5555);
    chk(chan_code[0], 16'h1234, "deferred held");
    load_n = 1'b0;
    repeat (4) @(negedge i_clk);
    load_n = 1'b1;
    repeat (10) @(negedge i_clk);
    chk(chan_code[0], 16'h5555, "pin load");
    wr(ADDR_CHAN_B_DATA, 16'h6666);
    chk(chan_code[1], 16'habcd, "deferred B held");
    wr(ADDR_TRIGGER, 16'h0010);
    chk(chan_code[1], 16'h6666, "software load");
    $display("test deferred update done");
    wr(ADDR_SYNC_SEL, 16'h0000);
    wr(ADDR_BCAST_SEL, 16'h0004);
    rchk(ADDR_BCAST_SEL, 16'h000d);
    wr(ADDR_GROUP_WRITE, 16'h0f0f);
    chk(chan_code[1], 16'h0f0f, "joined B");
    chk(chan_code[0], 16'h5555, "unjoined A");
    wr(ADDR_BCAST_SEL, 16'h0000);
    rchk(ADDR_BCAST_SEL, 16'h0009);
    wr(ADDR_BCAST_SEL, 16'h0006);
    wr(ADDR_GROUP_WRITE, 16'ha5a5);
    chk(chan_code, {16'ha5a5, 16'ha5a5}, "both joined");
    $display("test group write done");
    wr(ADDR_PWDN, 16'h0000);
    chk(chan_sleep, 2'b00, "awake");
    rchk(ADDR_PWDN, 16'h0ff9);
    wr(ADDR_PWDN, 16'h0004);
    chk(chan_sleep, 2'b10, "B asleep");
    $display("test sleep done");
    for (int i = 0; i < 11; i++)
    begin
      wr(ADDR_SPAN, {4'h0, codes[(i+1)%11], codes[i], 4'h0});
      chk(span_info[0], {1'b1, bip[i], volts[i]}, "span A");
      chk(span_info[1], {1'b1, bip[(i+1)%11], volts[(i+1)%11]}, "span B");
    end
    rchk(ADDR_SPAN, 16'h0000);
    $display("test span decode done");
    // A frame one bit short must leave every output alone; shifted by one bit it
    // would land on channel A data if the bit count were not checked.
    u_spi_host_model.xfer(1'b0, 7'h22, 16'h7777, 23, rx);
    chk(chan_code[0], 16'ha5a5, "short frame");
    rchk(7'h20, 16'h0000);
    $display("test refused frames done");
    finish_test();
  end

endmodule : test_dual_dac_channel_config_regs
